// ==== shared/wdt_consts.vh ====
`ifndef WDT_CONSTS_VH
`define WDT_CONSTS_VH

// register map
`define WDT_CTRL_OFFSET 12'h000
`define WDT_ADDR_LSB_MASK 12'h003

// control/status field positions
`define WDT_BIT_IRQ_FLAG 7
`define WDT_BIT_IRQ_ENABLE 6
`define WDT_BIT_SEL_MSB 5
`define WDT_BIT_UNLOCK 4
`define WDT_BIT_RESET_ENABLE 3
`define WDT_BIT_SEL_LO_HI 2
`define WDT_BIT_SEL_LO_LO 0

// reset values
`define WDT_RST_CTRL 8'h00
`define WDT_RST_SEL 4'h0
`define WDT_RST_UNLOCK_CNT 3'h0

// timing
`define WDT_UNLOCK_CYCLES 3'h4
`define WDT_BASE_PERIOD 21'h00_0800
`define WDT_SEL_MAX 4'h9

`endif

// ==== hdl/wdt_timer.v ====
`timescale 1ns/1ps
`default_nettype none
`include "wdt_consts.vh"

// What this block does
// - timeout in interrupt operation sets flag bit 7; taking the vector clears it
// - software writing one to the flag clears it; zero leaves it
// - interrupt requested only when flag, enable bit 6 and global enable are set
// - enable set, reset enable clear: interrupt only on every timeout, never reset
// - both enables set: first timeout sets the flag instead of resetting
// - combined mode: taking the vector clears interrupt enable and flag
// - combined mode: unserviced flag at next timeout gives a system reset
// - fuse clear: none stopped, reset enable alone resets, both interrupt then reset
// - clearing reset enable or changing timeout select needs change unlock bit 4
// - hardware clears change unlock four clock cycles after it was written
// - reset enable bit 3 reads and acts set while reset cause flag is set
// - timeout select: bit 5 is the top bit, bits 2..0 the low bits
// - select codes 0..9 give 2048 doubling to 1048576 oscillator cycles
// - after an unintended watchdog reset the watchdog stays enabled
// - counter advances on oscillator ticks and fires at the selected count
// - programmed fuse forces reset mode: reset enable one, interrupt enable zero
module wdt_timer #(
    parameter CNT_W = 21,
    parameter ADDR_W = 12
) (
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire osc_tick,
    input wire wdt_restart,
    input wire core_irq_enable,
    input wire irq_vector_taken,
    input wire always_on_fuse,
    input wire watchdog_reset_cause_flag,
    output reg timeout_irq,
    output reg sys_reset_req
);

    reg timeout_irq_flag;
    reg irq_enable_raw;
    reg reset_enable_raw;
    reg change_unlock;
    reg [2:0] unlock_cnt;
    reg [3:0] timeout_select;
    reg [CNT_W-1:0] wdt_count;

    reg next_flag;
    reg next_ie;
    reg next_re;
    reg next_unlock;
    reg [2:0] next_unlock_cnt;
    reg [3:0] next_sel;
    reg [CNT_W-1:0] next_count;
    reg next_reset_req;

    wire addr_hit;
    wire apb_access;
    wire reg_write;
    wire [7:0] wbyte;
    wire timeout_irq_enable;
    wire system_reset_enable;
    wire running;
    wire [3:0] sel_eff;
    wire [CNT_W-1:0] period;
    wire timeout;
    wire combined;
    wire [7:0] ctrl_rd;

    assign addr_hit = (paddr == `WDT_CTRL_OFFSET);
    assign apb_access = psel & penable & pready;
    assign reg_write = apb_access & pwrite & addr_hit & pstrb[0];
    assign wbyte = pwdata[7:0];

    // fuse locks the enables; cause flag holds reset enable
    assign timeout_irq_enable = irq_enable_raw & ~always_on_fuse;
    assign system_reset_enable = reset_enable_raw | always_on_fuse | watchdog_reset_cause_flag;

    // stopped only with both enables off
    assign running = timeout_irq_enable | system_reset_enable;
    assign combined = timeout_irq_enable & system_reset_enable;

    // reserved codes fall back to the longest period so a stray write never shortens it
    assign sel_eff = (timeout_select > `WDT_SEL_MAX) ? `WDT_SEL_MAX : timeout_select;
    assign period = `WDT_BASE_PERIOD << sel_eff;
    // >= so a switch to a shorter period fires at once rather than wrapping
    assign timeout = running & osc_tick & ((wdt_count + 1'b1) >= period);

    assign ctrl_rd = {timeout_irq_flag, timeout_irq_enable, timeout_select[3], change_unlock,
                      system_reset_enable, timeout_select[2:0]};

    always @* begin
        next_flag = timeout_irq_flag;
        next_ie = irq_enable_raw;
        next_re = reset_enable_raw;
        next_unlock = change_unlock;
        next_unlock_cnt = unlock_cnt;
        next_sel = timeout_select;
        next_count = wdt_count;
        next_reset_req = 1'b0;

        // unlock window ages on every enabled clock
        if (change_unlock) begin
            if (unlock_cnt == 3'h1) begin
                next_unlock = 1'b0;
                next_unlock_cnt = `WDT_RST_UNLOCK_CNT;
            end else begin
                next_unlock_cnt = unlock_cnt - 3'h1;
            end
        end

        // hardware clear on vector entry
        if (irq_vector_taken) begin
            next_flag = 1'b0;
            if (combined) begin
                next_ie = 1'b0;
            end
        end

        if (reg_write) begin
            if (wbyte[`WDT_BIT_IRQ_FLAG]) begin
                next_flag = 1'b0;
            end
            next_ie = wbyte[`WDT_BIT_IRQ_ENABLE];
            if (wbyte[`WDT_BIT_RESET_ENABLE]) begin
                next_re = 1'b1;
            end else if (change_unlock) begin
                next_re = 1'b0;
            end
            if (change_unlock) begin
                next_sel = {wbyte[`WDT_BIT_SEL_MSB], wbyte[`WDT_BIT_SEL_LO_HI:`WDT_BIT_SEL_LO_LO]};
            end
            // window only opens with unlock and reset enable written together
            if (wbyte[`WDT_BIT_UNLOCK] & wbyte[`WDT_BIT_RESET_ENABLE]) begin
                next_unlock = 1'b1;
                next_unlock_cnt = `WDT_UNLOCK_CYCLES;
            end
        end

        // counter; restart wins over a tick in the same cycle
        if (wdt_restart | ~running) begin
            next_count = {CNT_W{1'b0}};
        end else if (timeout) begin
            next_count = {CNT_W{1'b0}};
        end else if (osc_tick) begin
            next_count = wdt_count + 1'b1;
        end

        // timeout action; set of the flag wins over any clear this cycle
        if (timeout & ~wdt_restart) begin
            if (always_on_fuse) begin
                next_reset_req = 1'b1;
            end else if (combined) begin
                if (timeout_irq_flag) begin
                    next_reset_req = 1'b1;
                end else begin
                    next_flag = 1'b1;
                end
            end else if (timeout_irq_enable) begin
                next_flag = 1'b1;
            end else begin
                next_reset_req = 1'b1;
            end
        end
    end

    // control and counter state
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timeout_irq_flag <= 1'b0;
            irq_enable_raw <= 1'b0;
            reset_enable_raw <= 1'b0;
            change_unlock <= 1'b0;
            unlock_cnt <= `WDT_RST_UNLOCK_CNT;
            timeout_select <= `WDT_RST_SEL;
            wdt_count <= {CNT_W{1'b0}};
            sys_reset_req <= 1'b0;
            timeout_irq <= 1'b0;
        end else if (clk_en) begin
            timeout_irq_flag <= next_flag;
            irq_enable_raw <= next_ie;
            reset_enable_raw <= next_re;
            change_unlock <= next_unlock;
            unlock_cnt <= next_unlock_cnt;
            timeout_select <= next_sel;
            wdt_count <= next_count;
            sys_reset_req <= next_reset_req;
            // registered request, updated on the same clock as the flag
            timeout_irq <= next_flag & next_ie & ~always_on_fuse & core_irq_enable;
        end
    end

    // apb slave: no wait states, pready raised in the first access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (clk_en) begin
            if (psel & ~penable) begin
                pready <= 1'b1;
                pslverr <= ~addr_hit;
                prdata <= (addr_hit & ~pwrite) ? {24'h00_0000, ctrl_rd} : 32'h0000_0000;
            end else begin
                pready <= 1'b0;
                pslverr <= 1'b0;
                prdata <= 32'h0000_0000;
            end
        end
    end

endmodule // wdt_timer
`default_nettype wire

// ==== sim/wdt_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module wdt_props #(
    parameter ADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic osc_tick,
    input wire logic wdt_restart,
    input wire logic core_irq_enable,
    input wire logic irq_vector_taken,
    input wire logic always_on_fuse,
    input wire logic watchdog_reset_cause_flag,
    input wire logic timeout_irq,
    input wire logic sys_reset_req
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_pulse; sys_reset_req |=> !sys_reset_req; endproperty
    a_pulse: assert property (p_pulse) else $error("reset pulse too long");
    property p_tick; sys_reset_req |-> $past(osc_tick); endproperty
    a_tick: assert property (p_tick) else $error("reset without tick");
    property p_restart; wdt_restart |=> !sys_reset_req [*2]; endproperty
    a_restart: assert property (p_restart) else $error("reset after restart");
    property p_fuse; timeout_irq |-> !$past(always_on_fuse); endproperty
    a_fuse: assert property (p_fuse) else $error("irq under fuse");
    property p_cause; pready && !pwrite && !pslverr && watchdog_reset_cause_flag |-> prdata[3]; endproperty
    a_cause: assert property (p_cause) else $error("reset enable reads clear");
    property p_gate; timeout_irq |-> $past(core_irq_enable); endproperty
    a_gate: assert property (p_gate) else $error("irq while masked");
    property p_vec; irq_vector_taken && !osc_tick |=> !timeout_irq; endproperty
    a_vec: assert property (p_vec) else $error("flag kept after vector");
    // only a write that really lands: strobe lane zero, mapped address
    property p_swclr;
        psel && penable && pready && pwrite && paddr == 0 && pstrb[0] && pwdata[7] && !osc_tick |=> !timeout_irq;
    endproperty
    a_swclr: assert property (p_swclr) else $error("flag kept after clear");
    c_rst: cover property (sys_reset_req);
    c_irq: cover property ($rose(timeout_irq));
    c_err: cover property (pready && pslverr);
endmodule // wdt_props
bind wdt_timer wdt_props #(.ADDR_W(ADDR_W)) u_wdt_props (.*);
`default_nettype wire

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic [3:0] pstrb = 0;
    logic pready, pslverr, timeout_irq, sys_reset_req, irq_d = 0;
    logic osc_tick = 0, wdt_restart = 0, core_irq_enable = 1, irq_vector_taken = 0;
    logic always_on_fuse = 0, watchdog_reset_cause_flag = 0;
    int miscompares = 0, n_tests = 0;
    logic [32:0] rq[$];
    byte eq[$];
    wdt_timer u_wdt_timer (.*);
    always #2.5 pclk = ~pclk;
    task chk(logic [32:0] g, logic [32:0] e);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task chk_ev(byte g, byte e);
        chk({25'h0, g}, {25'h0, e});
    endtask
    // monitor: any unexpected irq rise or reset pulse pops a wrong note
    always @(posedge pclk) begin
        irq_d <= timeout_irq;
        if (psel && penable && pready && !pwrite) chk({pslverr, prdata}, rq.size() ? rq.pop_front() : 'x);
        if (sys_reset_req === 1) chk_ev("R", eq.size() ? eq.pop_front() : 0);
        if (timeout_irq === 1 && irq_d === 0) chk_ev("I", eq.size() ? eq.pop_front() : 0);
    end
    task apb(bit w, logic [11:0] a, logic [7:0] d);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'($urandom), d};
        pstrb <= {3'($urandom), 1'b1};
        @(posedge pclk) penable <= 1;
        do @(posedge pclk); while (pready !== 1);
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task rd(logic [7:0] e);
        rq.push_back({25'h0, e});
        apb(0, 12'h000, 8'h00);
    endtask
    task wr(logic [7:0] d);
        apb(1, 12'h000, d);
    endtask
    // idle edge after the burst so back-to-back calls never double-drive
    task tk(int n);
        osc_tick <= 1;
        repeat (n) @(posedge pclk);
        osc_tick <= 0;
        @(posedge pclk);
    endtask
    task rs;
        wdt_restart <= 1;
        @(posedge pclk) wdt_restart <= 0;
        @(posedge pclk);
    endtask
    task print_verdict;
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        logic [3:0] s;
        logic [7:0] v;
        void'($urandom(24451));
        repeat (8) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        rd(8'h00);
        rq.push_back({1'b1, 32'h0000_0000});
        apb(0, 12'h004, 8'h00);
        wr(8'h40);
        eq.push_back("I");
        tk(2048);
        wr(8'h40);
        rd(8'hc0);
        wr(8'hc0);
        rd(8'h40);
        wr(8'h48);
        rs;
        eq.push_back("I");
        tk(2048);
        rd(8'hc8);
        irq_vector_taken <= 1;
        @(posedge pclk) irq_vector_taken <= 0;
        rd(8'h08);
        eq.push_back("R");
        tk(2048);
        wr(8'h48);
        eq.push_back("I");
        tk(2048);
        eq.push_back("R");
        tk(2048);
        wr(8'h80);
        rd(8'h08);
        s = 4'($urandom % 10);
        v = {2'b00, s[3], 2'b00, s[2:0]};
        wr(8'h18);
        wr(v);
        rd(v);
        wr(8'h18);
        repeat (2) @(posedge pclk);
        wr(8'h00);
        rd(v | 8'h08);
        wr(8'h18);
        wr(8'h41);
        rs;
        tk(2000);
        rs;
        // ticks while frozen must not count
        clk_en <= 0;
        tk(8);
        clk_en <= 1;
        tk(4095);
        rd(8'h41);
        eq.push_back("I");
        tk(1);
        rd(8'hc1);
        core_irq_enable <= 0;
        @(posedge pclk) eq.push_back("I");
        core_irq_enable <= 1;
        repeat (2) @(posedge pclk);
        wr(8'hc1);
        watchdog_reset_cause_flag <= 1;
        rd(8'h49);
        watchdog_reset_cause_flag <= 0;
        wr(8'h18);
        wr(8'h41);
        rd(8'h41);
        always_on_fuse <= 1;
        rd(8'h09);
        rs;
        eq.push_back("R");
        tk(4096);
        repeat (4) @(posedge pclk);
        chk(33'(rq.size() + eq.size()), 33'h0_0000_0000);
        print_verdict;
    end
    initial begin
        repeat (40000) @(posedge pclk);
        miscompares++;
        print_verdict;
    end
endmodule // testbench
`default_nettype wire
